// >>> dv/psq_partner.sv
/* supply monitor and configuration source model.
   assumes clk is the bench clock; clock pin stands low when stopped. */
`timescale 1ns/1ps
`default_nettype none
module psq_partner (
   input wire logic  clk,
   input wire logic  arst_n,
   input wire logic  run_config_clock,
   input wire logic  supply_ok,
   input wire logic  source_reset_n,
   output logic      config_clock,
   output logic      power_down_n,
   output logic [15:0] edge_count
);
   logic [3:0] phase;
   // low only while supply is down, high through configuration
   assign power_down_n = supply_ok;
   assign config_clock = phase[3];
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase <= 4'h0;
         edge_count <= 16'h0000;
      end else begin
         phase <= run_config_clock ? phase + 4'h1 : 4'h0;
         if (!source_reset_n) edge_count <= 16'h0000;
         else if (run_config_clock && phase == 4'h7) edge_count <= edge_count + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// >>> dv/psq_sequencer_tb_top.sv
/* self-checking bench for the sequencer.
   assumes shortened power-on and clear counts; 16 clk per config period. */
`timescale 1ns/1ps
`default_nettype none
module psq_sequencer_tb_top;
   logic clk = 1'b0, arst_n = 1'b0, run_config_clock = 1'b0, supply_ok = 1'b1;
   logic reset_in_n = 1'b1, config_load_done = 1'b0, done_after_io = 1'b0;
   logic reset_before_io = 1'b0, osc_cfg_loaded = 1'b0;
   logic [7:0] pad_in = 8'h00, pad_in_int, pad_oe;
   logic power_down_n, config_clock, pad_pullup_en, longline_pullup_en, osc_enable;
   logic config_done, logic_live, global_reset_n, user_clock_en, source_reset_n;
   logic config_valid, low_during_config_n, chip_pulse;
   logic [15:0] edge_count;
   int num_errors = 0, samples_checked = 0, pulses = 0;
   always #4 clk = ~clk;
   always @(posedge clk) if (chip_pulse === 1'b1) pulses++;
   psq_sequencer #(.POR_MASTER_LEN(8), .POR_SLAVE_LEN(4), .CLEAR_LEN(2)) psq_sequencer_inst (
      .clk(clk), .arst_n(arst_n), .power_down_n(power_down_n),
      .config_clock(config_clock), .reset_in_n(reset_in_n), .master_mode(1'b1),
      .config_load_done(config_load_done), .osc_cfg_loaded(osc_cfg_loaded),
      .done_after_io(done_after_io), .reset_before_io(reset_before_io),
      .pad_in(pad_in), .user_oe(8'hFF), .pad_in_int(pad_in_int), .pad_oe(pad_oe),
      .pad_pullup_en(pad_pullup_en), .longline_pullup_en(longline_pullup_en),
      .osc_enable(osc_enable), .config_done(config_done), .config_valid(config_valid),
      .logic_live(logic_live), .global_reset_n(global_reset_n),
      .user_clock_en(user_clock_en), .low_during_config_n(low_during_config_n),
      .chip_reset_o(),
      .chip_reset_oe(chip_pulse), .source_reset_n(source_reset_n));
   psq_partner psq_partner_inst (.clk(clk), .arst_n(arst_n), .run_config_clock(run_config_clock),
      .supply_ok(supply_ok), .source_reset_n(source_reset_n),
      .config_clock(config_clock), .power_down_n(power_down_n), .edge_count(edge_count));
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("errors %0d, comparisons %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic meas_startup(input logic dai, input logic rbi);
      int td, ti, tr, i;
      td = -1; ti = -1; tr = -1;
      for (i = 0; i < 200; i++) begin
         step(1);
         if (td < 0 && config_done === 1'b1) td = i;
         if (ti < 0 && pad_oe === 8'hFF) ti = i;
         if (tr < 0 && global_reset_n === 1'b1) tr = i;
      end
      check(32'(ti - td), dai ? -32'sd16 : 32'sd16);
      check(32'(tr - ti), rbi ? -32'sd16 : 32'sd16);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_power_on;
      int i;
      run_config_clock = 1'b1;
      for (i = 0; i < 400 && logic_live !== 1'b1; i++) step(1);
      check(edge_count, 16'd10);
      check(pad_oe, 8'h00);
      check(pad_pullup_en, 1'b1);
      check(global_reset_n, 1'b0);
      check(osc_enable, 1'b0);
      check({config_valid, low_during_config_n}, 2'h0);
      osc_cfg_loaded = 1'b1;
      step(1);
      check(osc_enable, 1'b1);
   endtask
   task automatic t_restart;
      int i;
      reset_in_n = 1'b0;
      step(8);
      check(source_reset_n, 1'b0);
      check(logic_live, 1'b0);
      reset_in_n = 1'b1;
      for (i = 0; i < 200 && logic_live !== 1'b1; i++) step(1);
      check(source_reset_n, 1'b1);
      check(logic_live, 1'b1);
   endtask
   task automatic t_startup;
      config_load_done = 1'b1;
      meas_startup(1'b0, 1'b0);
      check(pulses, 1);
      check({config_valid, low_during_config_n}, 2'h3);
   endtask
   task automatic t_powerdown;
      pad_in = 8'h5A;
      supply_ok = 1'b0;
      step(12);
      check(pad_oe, 8'h00);
      check({pad_pullup_en, longline_pullup_en, osc_enable}, 3'h0);
      check(pad_in_int, 8'hFF);
      check({global_reset_n, config_done, user_clock_en}, 3'h0);
      check(logic_live, 1'b1);
      step(48);
      check(config_done, 1'b0);
      done_after_io = 1'b1;
      reset_before_io = 1'b1;
      supply_ok = 1'b1;
      meas_startup(1'b1, 1'b1);
      check(pad_in_int, 8'h5A);
      check(pulses, 1);
   endtask
   initial begin
      step(3);
      arst_n = 1'b1;
      step(2);
      t_power_on();
      t_restart();
      t_startup();
      t_powerdown();
      finish_test();
   end
   initial begin
      #40000;
      num_errors++;
      finish_test();
   end
endmodule
`default_nettype wire
bind psq_sequencer psq_sva #(.N_PADS(N_PADS)) psq_sva_inst (.clk(clk), .arst_n(arst_n),
   .power_down_n(power_down_n), .pad_in_int(pad_in_int), .pad_oe(pad_oe),
   .pad_pullup_en(pad_pullup_en), .longline_pullup_en(longline_pullup_en),
   .osc_enable(osc_enable), .config_done(config_done), .logic_live(logic_live),
   .global_reset_n(global_reset_n), .user_clock_en(user_clock_en),
   .low_during_config_n(low_during_config_n), .chip_reset_oe(chip_reset_oe));

// >>> dv/psq_sva.sv
/* port assertions for the power-down and start-up sequencer.
   assumes a bind into psq_sequencer, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module psq_sva #(
   parameter int unsigned N_PADS = 8
) (
   input wire logic              clk,
   input wire logic              arst_n,
   input wire logic              power_down_n,
   input wire logic [N_PADS-1:0] pad_in_int,
   input wire logic [N_PADS-1:0] pad_oe,
   input wire logic              pad_pullup_en,
   input wire logic              longline_pullup_en,
   input wire logic              osc_enable,
   input wire logic              config_done,
   input wire logic              logic_live,
   input wire logic              global_reset_n,
   input wire logic              user_clock_en,
   input wire logic              low_during_config_n,
   input wire logic              chip_reset_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic pulsed_ff;
   logic nxt_pulsed_ff;
   always_comb begin
      nxt_pulsed_ff = pulsed_ff;
      if (!low_during_config_n) nxt_pulsed_ff = 1'b0;
      else if (chip_reset_oe) nxt_pulsed_ff = 1'b1;
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) pulsed_ff <= 1'b0;
      else pulsed_ff <= nxt_pulsed_ff;
   end
   sequence s_pd_held;
      !power_down_n [*8];
   endsequence
   sequence s_gen_pulse;
      chip_reset_oe ##1 !chip_reset_oe;
   endsequence
   property p_pd_tristate;
      s_pd_held |-> pad_oe == '0;
   endproperty
   property p_pd_pullups;
      s_pd_held |-> !pad_pullup_en && !longline_pullup_en;
   endproperty
   property p_pd_osc;
      s_pd_held |-> !osc_enable;
   endproperty
   property p_pd_inputs;
      s_pd_held |-> pad_in_int == '1;
   endproperty
   property p_pd_storage;
      s_pd_held |-> !global_reset_n && !config_done;
   endproperty
   property p_pd_logic;
      s_pd_held |-> logic_live;
   endproperty
   property p_gen_pulse;
      $rose(chip_reset_oe) |-> !global_reset_n && low_during_config_n ##0 s_gen_pulse;
   endproperty
   property p_single_pulse;
      chip_reset_oe |-> !pulsed_ff;
   endproperty
   property p_activation;
      $rose(user_clock_en) |-> !pad_pullup_en && low_during_config_n;
   endproperty
   a_pd_tristate: assert property (p_pd_tristate)
      else $error("outputs driven in power-down");
   a_pd_pullups: assert property (p_pd_pullups)
      else $error("pull-up on in power-down");
   a_pd_osc: assert property (p_pd_osc)
      else $error("oscillator on in power-down");
   a_pd_inputs: assert property (p_pd_inputs)
      else $error("inputs not forced high in power-down");
   a_pd_storage: assert property (p_pd_storage)
      else $error("storage not reset in power-down");
   a_pd_logic: assert property (p_pd_logic)
      else $error("logic stopped in power-down");
   a_gen_pulse: assert property (p_gen_pulse)
      else $error("reset pulse not one cycle");
   a_single_pulse: assert property (p_single_pulse)
      else $error("second reset pulse");
   a_activation: assert property (p_activation)
      else $error("activation not simultaneous");
endmodule
`default_nettype wire

// >>> pkg/psq_pkg.sv
/*
 * constants, states and types of the power-down and start-up sequencer.
 * assumes one system clock; the configuration clock arrives as a pin.
 */
`default_nettype none
package psq_pkg;

   // -----------------------------------------------------------------
   // widths and synchroniser
   // -----------------------------------------------------------------
   localparam int unsigned SYNC_DEPTH   = 3;
   localparam int unsigned POR_CNT_W    = 17;
   localparam int unsigned STEP_W       = 2;

   typedef logic [POR_CNT_W-1:0] psq_cnt_t;
   typedef logic [STEP_W-1:0]    psq_step_t;

   // -----------------------------------------------------------------
   // power-on delay and memory clear, in configuration-clock periods
   // -----------------------------------------------------------------
   localparam int unsigned POR_MASTER_PERIODS = 65536;
   localparam int unsigned POR_SLAVE_PERIODS  = 16384;
   localparam int unsigned CLEAR_FRAMES       = 16;

   // -----------------------------------------------------------------
   // start-up steps, one per configuration-clock rising edge
   // -----------------------------------------------------------------
   localparam psq_step_t STEP_IDLE  = 2'h0;
   localparam psq_step_t STEP_FIRST = 2'h1;
   localparam psq_step_t STEP_IO    = 2'h2;
   localparam psq_step_t STEP_LAST  = 2'h3;

   localparam psq_cnt_t CNT_ZERO = 17'h00000;
   localparam psq_cnt_t CNT_ONE  = 17'h00001;

   // -----------------------------------------------------------------
   // sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_POR,
      ST_CLEAR,
      ST_CONFIG,
      ST_STARTUP,
      ST_ACTIVE,
      ST_PWRDN
   } psq_state_e;

endpackage
`default_nettype wire

// >>> rtl/psq_sequencer.sv
/*
 * power-down hold state, start-up ordering on the configuration clock,
 * and the one-shot system reset pulse generator.
 * assumes clk is the system clock; config_clock, power_down_n, reset_in_n
 * and the pads come from pins; the loader signals run on clk.
 */
// Operation
// R1: low power-down input halts all internal activity for minimal supply current.
// R2: power-down switches off all pull-ups on long lines and pads.
// R3: power-down stops the crystal oscillator.
// R4: power-down places every package output in high impedance.
// R5: power-down presents constant high inputs to internal logic.
// R6: power-down holds every flip-flop and latch in reset.
// R7: power-down keeps configuration; combinational logic keeps evaluating.
// R8: power-down ignores every clock.
// R9: leaving power-down reruns the end-of-configuration start-up sequence.
// R10: outside party keeps power-down high throughout configuration.
// R11: outside party drives power-down low before supply sags below threshold.
// R12: outside party releases power-down only after supply recovers.
// R13: completion flag rises one period before or after I/O activation.
// R14: global reset releases one period before or after I/O activation.
// R15: default order is flag, then I/O, then reset release.
// R16: before activation unused pins float with weak pull-ups, storage reset.
// R17: activation on a rising configuration-clock edge, outputs and clocks together.
// R18: daisy-chained devices activate on the same configuration-clock edge.
// R19: logic and oscillator run once configured; storage reset, outputs float.
// R20: reset generator latch sets while low-during-config asserted, then holds.
// R21: first system edge after configuration makes one chip reset pulse.
// R22: generator never pulses again after its single pulse.
// R23: reset input toggling aborts configuration, clears memory, restarts source.
// R24: configuration clock times a long master or short slave power-on delay.
// R25: configuration-clock events are synchronised before system-clock use.
`timescale 1ns/1ps
`default_nettype none
module psq_sequencer #(
   parameter int unsigned N_PADS         = 8,
   parameter int unsigned POR_MASTER_LEN = psq_pkg::POR_MASTER_PERIODS,
   parameter int unsigned POR_SLAVE_LEN  = psq_pkg::POR_SLAVE_PERIODS,
   parameter int unsigned CLEAR_LEN      = psq_pkg::CLEAR_FRAMES
) (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              power_down_n,
   input  wire logic              config_clock,
   input  wire logic              reset_in_n,
   input  wire logic              master_mode,
   input  wire logic              config_load_done,
   input  wire logic              osc_cfg_loaded,
   input  wire logic              done_after_io,
   input  wire logic              reset_before_io,
   input  wire logic [N_PADS-1:0] pad_in,
   input  wire logic [N_PADS-1:0] user_oe,
   output logic      [N_PADS-1:0] pad_in_int,
   output logic      [N_PADS-1:0] pad_oe,
   output logic                   pad_pullup_en,
   output logic                   longline_pullup_en,
   output logic                   osc_enable,
   output logic                   config_done,
   output logic                   config_valid,
   output logic                   logic_live,
   output logic                   global_reset_n,
   output logic                   user_clock_en,
   output logic                   low_during_config_n,
   output logic                   chip_reset_o,
   output logic                   chip_reset_oe,
   output logic                   source_reset_n
);

   // -----------------------------------------------------------------
   // state record
   // -----------------------------------------------------------------
   typedef struct packed {
      psq_pkg::psq_state_e state;
      logic [psq_pkg::SYNC_DEPTH-1:0] cc_s;
      logic [psq_pkg::SYNC_DEPTH-1:0] pd_s;
      logic [psq_pkg::SYNC_DEPTH-1:0] rs_s;
      logic                cc_f;
      logic                pd_f;
      logic                rs_f;
      logic [N_PADS-1:0]   pin_s0;
      logic [N_PADS-1:0]   pin_s1;
      logic [N_PADS-1:0]   pin_s2;
      logic [N_PADS-1:0]   pin_f;
      logic [N_PADS-1:0]   pin_int;
      psq_pkg::psq_cnt_t   cnt;
      psq_pkg::psq_step_t  step;
      logic                strap_done;
      logic                master;
      logic                done;
      logic                io_act;
      logic                grst_rel;
      logic                ldc_n;
      logic                latch;
      logic                gen_q;
      logic                restart;
   } psq_state_s;

   psq_state_s st_ff;
   psq_state_s nxt_st;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic agree(input logic [psq_pkg::SYNC_DEPTH-1:0] s,
                                  input logic                          f);
      // filtered level moves once the two later stages agree
      agree = (s[1] == s[2]) ? s[2] : f;
   endfunction

   function automatic psq_pkg::psq_cnt_t last_of(input int unsigned len);
      last_of = psq_pkg::psq_cnt_t'(len - 1);
   endfunction

   logic cc_rise;
   logic pd_rise;
   logic pd_fall;
   logic rs_fall;
   logic in_pwrdn;
   psq_pkg::psq_cnt_t por_last;

   always_comb begin
      cc_rise  = nxt_st.cc_f & ~st_ff.cc_f; // R25
      pd_rise  = nxt_st.pd_f & ~st_ff.pd_f;
      pd_fall  = ~nxt_st.pd_f & st_ff.pd_f;
      rs_fall  = ~nxt_st.rs_f & st_ff.rs_f;
      in_pwrdn = (st_ff.state == psq_pkg::ST_PWRDN);
      por_last = st_ff.master ? last_of(POR_MASTER_LEN) : last_of(POR_SLAVE_LEN); // R24
   end

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;

      // pin synchronisers, first stage read only by the second
      nxt_st.cc_s   = {st_ff.cc_s[1:0], config_clock};
      nxt_st.pd_s   = {st_ff.pd_s[1:0], power_down_n};
      nxt_st.rs_s   = {st_ff.rs_s[1:0], reset_in_n};
      nxt_st.cc_f   = agree(st_ff.cc_s, st_ff.cc_f);
      nxt_st.pd_f   = agree(st_ff.pd_s, st_ff.pd_f);
      nxt_st.rs_f   = agree(st_ff.rs_s, st_ff.rs_f);
      nxt_st.pin_s0 = pad_in;
      nxt_st.pin_s1 = st_ff.pin_s0;
      nxt_st.pin_s2 = st_ff.pin_s1;
      for (int i = 0; i < int'(N_PADS); i++) begin
         nxt_st.pin_f[i] = (st_ff.pin_s1[i] == st_ff.pin_s2[i]) ? st_ff.pin_s2[i]
                                                                : st_ff.pin_f[i];
      end

      // strap caught on the first edge after reset release
      if (!st_ff.strap_done) begin
         nxt_st.strap_done = 1'b1;
         nxt_st.master     = master_mode;
      end

      // inputs forced high in power-down, else seen by live logic
      nxt_st.pin_int = in_pwrdn ? {N_PADS{1'b1}} : st_ff.pin_f; // R5 R19
      nxt_st.restart = 1'b0;

      case (st_ff.state)
         psq_pkg::ST_POR: begin
            if (cc_rise && st_ff.strap_done) begin // R24
               if (st_ff.cnt == por_last) begin
                  nxt_st.cnt   = psq_pkg::CNT_ZERO;
                  nxt_st.state = psq_pkg::ST_CLEAR;
               end else begin
                  nxt_st.cnt = st_ff.cnt + psq_pkg::CNT_ONE;
               end
            end
         end
         psq_pkg::ST_CLEAR: begin
            // one configuration-clock period per cleared frame
            if (!st_ff.rs_f) begin
               nxt_st.restart = 1'b1; // R23
               nxt_st.cnt     = psq_pkg::CNT_ZERO;
            end else if (cc_rise) begin
               if (st_ff.cnt == last_of(CLEAR_LEN)) begin
                  nxt_st.cnt   = psq_pkg::CNT_ZERO;
                  nxt_st.state = psq_pkg::ST_CONFIG;
               end else begin
                  nxt_st.cnt = st_ff.cnt + psq_pkg::CNT_ONE;
               end
            end
         end
         psq_pkg::ST_CONFIG: begin
            // power-down is kept high by the outside party here
            if (rs_fall || !st_ff.rs_f) begin // R10 R23
               nxt_st.state   = psq_pkg::ST_CLEAR;
               nxt_st.cnt     = psq_pkg::CNT_ZERO;
               nxt_st.restart = 1'b1;
            end else if (config_load_done) begin
               nxt_st.state = psq_pkg::ST_STARTUP;
               nxt_st.step  = psq_pkg::STEP_IDLE;
            end
         end
         psq_pkg::ST_STARTUP: begin
            if (!st_ff.rs_f && !st_ff.ldc_n) begin
               nxt_st.state    = psq_pkg::ST_CLEAR; // R23
               nxt_st.cnt      = psq_pkg::CNT_ZERO;
               nxt_st.restart  = 1'b1;
               nxt_st.done     = 1'b0;
               nxt_st.io_act   = 1'b0;
               nxt_st.grst_rel = 1'b0;
            end else if (cc_rise) begin // R17 R18
               nxt_st.step = st_ff.step + psq_pkg::STEP_FIRST;
               case (st_ff.step)
                  psq_pkg::STEP_IDLE: begin
                     if (!done_after_io) begin
                        nxt_st.done = 1'b1; // R13 R15
                     end
                     if (reset_before_io) begin
                        nxt_st.grst_rel = 1'b1; // R14
                     end
                  end
                  psq_pkg::STEP_FIRST: begin
                     nxt_st.io_act = 1'b1; // R17 R15
                     nxt_st.ldc_n  = 1'b1;
                  end
                  default: begin
                     nxt_st.done     = 1'b1; // R13
                     nxt_st.grst_rel = 1'b1; // R14 R15
                     nxt_st.state    = psq_pkg::ST_ACTIVE;
                     nxt_st.step     = psq_pkg::STEP_IDLE;
                  end
               endcase
            end
         end
         psq_pkg::ST_ACTIVE: begin
            // outside party drops power-down ahead of a supply sag
            if (pd_fall || !st_ff.pd_f) begin // R11 R1
               nxt_st.state    = psq_pkg::ST_PWRDN;
               nxt_st.done     = 1'b0;
               nxt_st.io_act   = 1'b0;
               nxt_st.grst_rel = 1'b0;
            end
         end
         psq_pkg::ST_PWRDN: begin
            // clocks ignored; release only after supply recovery
            if (pd_rise) begin // R8 R12 R9
               nxt_st.state = psq_pkg::ST_STARTUP;
               nxt_st.step  = psq_pkg::STEP_IDLE;
            end
         end
         default: begin
            nxt_st.state = psq_pkg::ST_POR;
         end
      endcase

      // one-shot reset generator on the system clock
      if (!st_ff.ldc_n) begin
         nxt_st.latch = 1'b1; // R20
      end else if (st_ff.gen_q) begin
         nxt_st.latch = 1'b0; // R21 R22
      end
      if (in_pwrdn || !st_ff.grst_rel || !st_ff.ldc_n) begin
         nxt_st.gen_q = 1'b0; // R6 R20
      end else begin
         nxt_st.gen_q = st_ff.latch & ~st_ff.gen_q; // R21
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff.state      <= psq_pkg::ST_POR;
         st_ff.cc_s       <= '0;
         st_ff.pd_s       <= '0;
         st_ff.rs_s       <= '0;
         st_ff.cc_f       <= 1'b0;
         st_ff.pd_f       <= 1'b0;
         st_ff.rs_f       <= 1'b0;
         st_ff.pin_s0     <= '0;
         st_ff.pin_s1     <= '0;
         st_ff.pin_s2     <= '0;
         st_ff.pin_f      <= '0;
         st_ff.pin_int    <= '0;
         st_ff.cnt        <= psq_pkg::CNT_ZERO;
         st_ff.step       <= psq_pkg::STEP_IDLE;
         st_ff.strap_done <= 1'b0;
         st_ff.master     <= 1'b0;
         st_ff.done       <= 1'b0;
         st_ff.io_act     <= 1'b0;
         st_ff.grst_rel   <= 1'b0;
         st_ff.ldc_n      <= 1'b0;
         st_ff.latch      <= 1'b0;
         st_ff.gen_q      <= 1'b0;
         st_ff.restart    <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   logic active_io;
   always_comb begin
      active_io          = st_ff.io_act & ~in_pwrdn;
      pad_in_int         = st_ff.pin_int; // R5
      pad_oe             = user_oe & {N_PADS{active_io}}; // R4 R16 R19
      pad_pullup_en      = ~st_ff.io_act & ~in_pwrdn; // R2 R16
      longline_pullup_en = ~in_pwrdn; // R2
      osc_enable         = osc_cfg_loaded & ~in_pwrdn; // R3 R19
      config_done        = st_ff.done;
      config_valid       = (st_ff.state == psq_pkg::ST_STARTUP) |
                           (st_ff.state == psq_pkg::ST_ACTIVE) | in_pwrdn; // R7
      logic_live         = (st_ff.state != psq_pkg::ST_POR) &
                           (st_ff.state != psq_pkg::ST_CLEAR); // R7 R19
      global_reset_n     = st_ff.grst_rel & ~in_pwrdn & ~st_ff.gen_q; // R6 R16 R21
      user_clock_en      = active_io; // R1 R8 R17
      low_during_config_n = st_ff.ldc_n;
      chip_reset_o       = 1'b0;
      chip_reset_oe      = st_ff.gen_q; // R21
      source_reset_n     = ~st_ff.restart; // R23
   end

endmodule
`default_nettype wire
